// [run_cmd_pkg.sv]
// Purpose: Shared constants for the run command input decoder.
// Assumes: Registers are reached over classic Wishbone with 32-bit data.
// Notes: Function codes follow the terminal assignment codes of the drive.
package run_cmd_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [7:0] FUNC_LO_OFFSET = 8'h00;
    localparam logic [7:0] FUNC_HI_OFFSET = 8'h04;
    localparam logic [7:0] NC_CFG_OFFSET = 8'h08;
    localparam logic [7:0] KEYPAD_CTRL_OFFSET = 8'h0c;
    localparam logic [7:0] RUN_STATUS_OFFSET = 8'h10;

    // ************************************************************
    // Terminal function codes
    // ************************************************************
    localparam logic [7:0] FUNC_FORWARD_RUN = 8'h00;
    localparam logic [7:0] FUNC_REVERSE_RUN = 8'h01;
    localparam logic [7:0] FUNC_SECOND_SET = 8'h08;
    localparam logic [7:0] FUNC_NOT_USED = 8'hff;
    localparam int TERMINAL_COUNT = 7;
    localparam int TERMS_PER_WORD = 4;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int KEYPAD_DIR_BIT = 0;
    localparam int KEYPAD_RUN_BIT = 1;
    localparam int STAT_RUNNING_BIT = 0;
    localparam int STAT_REVERSE_BIT = 1;
    localparam int STAT_ACTIVE_SET_BIT = 2;
    localparam int STAT_SELECTED_SET_BIT = 3;
    localparam int STAT_MAIN_POWER_BIT = 4;
    localparam int STAT_FORWARD_CMD_BIT = 5;
    localparam int STAT_REVERSE_CMD_BIT = 6;
    localparam int STAT_LEVELS_LSB = 8;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [7:0] NC_CFG_RESET = 8'h00;
    localparam logic KEYPAD_DIR_RESET = 1'b0;
    localparam logic KEYPAD_RUN_RESET = 1'b0;

endpackage : run_cmd_pkg

// [level_sync.sv]
// Purpose: Two flip-flop synchroniser for a group of slow levels.
// Assumes: Each bit is an independent level; no bus coherency is needed.
// Notes: Only the second stage is visible outside.
`timescale 1ns/1ps
module level_sync #(
    parameter int WIDTH = 8
) (
    input wire logic clock,
    input wire logic rstSync_n,
    input wire logic [WIDTH-1:0] levelIn,
    output logic [WIDTH-1:0] levelOut
);

    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } sync_s;

    sync_s state_r;
    sync_s state_nxt;

    if (WIDTH < 1) begin : g_bad_width
        $error("level_sync needs WIDTH of at least 1.");
    end

    always_comb begin
        state_nxt = state_r;
        state_nxt.stage1 = levelIn;
        state_nxt.stage2 = state_r.stage1;
    end

    always_ff @(posedge clock or negedge rstSync_n) begin
        if (!rstSync_n) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign levelOut = state_r.stage2;

endmodule : level_sync

// [run_command_input_decode.sv]
// Purpose: Decode programmable input terminals into run, direction and motor set.
// Assumes: Terminal levels and main power status are slow levels from outside.
// Notes: Registers sit on a classic Wishbone slave with a one-cycle answer.
//
// How it works
// RULE1: A terminal set to code 00 that is asserted runs the motor forward, else stop; here the keypad run bit still runs the motor without it.
// RULE2: A terminal set to code 01 that is asserted runs the motor in reverse, else stop; here the keypad run bit still runs the motor without it.
// RULE3: Forward and reverse commands active together give stop, never a direction.
// RULE4: A normally closed forward or reverse terminal that is open counts as a run command.
// RULE5: Seven identical terminals, each may carry forward, reverse or set select.
// RULE6: The keypad run direction setting never changes how terminal commands decode.
// RULE7: A run command already present when reset ends starts the motor at once.
// RULE8: A terminal set to code 08 selects the second motor set when asserted, else the first.
// RULE9: A set select change while running only takes effect once the drive has stopped.
// RULE10: Without main power the registers still work but the motor is never driven.
// RULE11: Each terminal is synchronised and then inverted if normally closed before decoding.
//
// Chosen here: the Wishbone register port and the address map.
`timescale 1ns/1ps
module run_command_input_decode
    import run_cmd_pkg::*;
#(
    parameter int TERMS = run_cmd_pkg::TERMINAL_COUNT
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [TERMS-1:0] terminalIn,
    input wire logic mainPowerOk,
    output logic motorRun,
    output logic motorReverse,
    output logic secondSetActive
);
    import run_cmd_pkg::*;

    // ************************************************************
    // Checks and types
    // ************************************************************
    // A ninth terminal would find no byte left in the two function words.
    if (TERMS < 1 || TERMS > 2 * TERMS_PER_WORD) begin : g_bad_terms
        $error("TERMS must lie between 1 and 8 to fit the function registers.");
    end

    // The levels field of the status word must stay inside the word.
    if (STAT_LEVELS_LSB + TERMS > 32) begin : g_bad_levels
        $error("The terminal levels do not fit in the status word.");
    end

    // Status flags below the levels field must not overlap it.
    if (STAT_REVERSE_CMD_BIT >= STAT_LEVELS_LSB) begin : g_bad_flags
        $error("Status flags overlap the terminal levels field.");
    end

    // Keypad writes honour byte lane 0 only, so its bits must sit there.
    if (KEYPAD_DIR_BIT > 7 || KEYPAD_RUN_BIT > 7) begin : g_bad_keypad
        $error("Keypad control bits must sit in the lowest byte.");
    end

    typedef struct packed {
        logic [TERMS-1:0][7:0] funcCode;
        logic [TERMS-1:0] ncCfg;
        logic keypadRunDirectionSetting;
        logic keypadRun;
        logic running;
        logic reverse;
        logic activeSet;
        logic ack;
        logic [31:0] rdData;
    } state_s;

    state_s state_r;
    state_s state_nxt;
    logic [1:0] rstPipe_r;
    logic rstSync_n;
    logic [TERMS:0] syncLevels;
    logic [TERMS-1:0] termLevel;
    logic powerOk;
    logic forward_run_cmd;
    logic reverse_run_cmd;
    logic setSelect;
    logic runWanted;
    logic reverseWanted;
    logic [31:0] statusWord;

    // ************************************************************
    // Reset release
    // ************************************************************
    // Reset asserts at once but releases only after two clean edges.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rstPipe_r <= 2'b00;
        end else begin
            rstPipe_r <= {rstPipe_r[0], 1'b1};
        end
    end

    assign rstSync_n = rstPipe_r[1];

    // ************************************************************
    // Input synchronisation
    // ************************************************************
    level_sync #(
        .WIDTH(TERMS + 1)
    ) u_sync (
        .clock(clock),
        .rstSync_n(rstSync_n),
        .levelIn({mainPowerOk, terminalIn}),
        .levelOut(syncLevels)
    ); // see RULE11

    assign powerOk = syncLevels[TERMS];
    assign termLevel = syncLevels[TERMS-1:0] ^ state_r.ncCfg; // see RULE11 see RULE4

    // ************************************************************
    // Function decode
    // ************************************************************
    // Any terminal may carry any function, so every terminal is scanned.
    always_comb begin
        forward_run_cmd = 1'b0;
        reverse_run_cmd = 1'b0;
        setSelect = 1'b0;
        for (int i = 0; i < TERMS; i++) begin // see RULE5
            if (termLevel[i] && state_r.funcCode[i] == FUNC_FORWARD_RUN) begin
                forward_run_cmd = 1'b1; // see RULE1
            end
            if (termLevel[i] && state_r.funcCode[i] == FUNC_REVERSE_RUN) begin
                reverse_run_cmd = 1'b1; // see RULE2
            end
            if (termLevel[i] && state_r.funcCode[i] == FUNC_SECOND_SET) begin
                setSelect = 1'b1; // see RULE8
            end
        end
    end

    // ************************************************************
    // Run decision
    // ************************************************************
    // Terminals outrank the keypad run key, so a wired command cannot be overridden.
    always_comb begin
        runWanted = 1'b0;
        reverseWanted = state_r.reverse;
        // Losing main power stops the motor even with a command held.
        if (!powerOk) begin
            runWanted = 1'b0; // see RULE10
        end else if (forward_run_cmd && reverse_run_cmd) begin
            runWanted = 1'b0; // see RULE3
        end else if (forward_run_cmd || reverse_run_cmd) begin
            runWanted = 1'b1; // see RULE1 see RULE2 see RULE7
            reverseWanted = reverse_run_cmd; // see RULE6
        end else if (state_r.keypadRun) begin
            // Only the keypad run key obeys the keypad direction setting.
            runWanted = 1'b1;
            reverseWanted = state_r.keypadRunDirectionSetting; // see RULE6
        end else begin
            runWanted = 1'b0; // see RULE1 see RULE2
        end
    end

    // ************************************************************
    // Status word
    // ************************************************************
    // Levels show the terminals after inversion, exactly as the decoder sees them.
    always_comb begin
        statusWord = '0;
        statusWord[STAT_RUNNING_BIT] = state_r.running;
        statusWord[STAT_REVERSE_BIT] = state_r.reverse;
        statusWord[STAT_ACTIVE_SET_BIT] = state_r.activeSet;
        statusWord[STAT_SELECTED_SET_BIT] = setSelect;
        statusWord[STAT_MAIN_POWER_BIT] = powerOk;
        statusWord[STAT_FORWARD_CMD_BIT] = forward_run_cmd;
        statusWord[STAT_REVERSE_CMD_BIT] = reverse_run_cmd;
        statusWord[STAT_LEVELS_LSB +: TERMS] = termLevel;
    end

    // ************************************************************
    // Register access and run state
    // ************************************************************
    function automatic logic [31:0] merge_bytes(
        input logic [31:0] oldWord,
        input logic [31:0] newWord,
        input logic [3:0] sel
    );
        logic [31:0] result;
        result = oldWord;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                result[b*8 +: 8] = newWord[b*8 +: 8];
            end
        end
        return result;
    endfunction : merge_bytes

    always_comb begin
        logic [2*TERMS_PER_WORD-1:0][7:0] funcWide;
        logic [31:0] word;
        logic doWrite;
        funcWide = {(2 * TERMS_PER_WORD){FUNC_NOT_USED}};
        word = '0;
        doWrite = 1'b0;
        state_nxt = state_r;

        for (int i = 0; i < TERMS; i++) begin
            funcWide[i] = state_r.funcCode[i];
        end

        // The answer comes one cycle after the request and drops the next cycle.
        state_nxt.ack = wb_cyc_i && wb_stb_i && !state_r.ack;
        doWrite = state_nxt.ack && wb_we_i;

        if (doWrite) begin
            unique case (wb_adr_i)
                FUNC_LO_OFFSET: begin
                    word = merge_bytes(funcWide[TERMS_PER_WORD-1:0], wb_dat_i, wb_sel_i);
                    funcWide[TERMS_PER_WORD-1:0] = word;
                end
                FUNC_HI_OFFSET: begin
                    word = merge_bytes(funcWide[2*TERMS_PER_WORD-1:TERMS_PER_WORD],
                        wb_dat_i, wb_sel_i);
                    funcWide[2*TERMS_PER_WORD-1:TERMS_PER_WORD] = word;
                end
                NC_CFG_OFFSET: begin
                    if (wb_sel_i[0]) begin
                        state_nxt.ncCfg = wb_dat_i[TERMS-1:0];
                    end
                end
                KEYPAD_CTRL_OFFSET: begin
                    if (wb_sel_i[0]) begin
                        state_nxt.keypadRunDirectionSetting = wb_dat_i[KEYPAD_DIR_BIT];
                        state_nxt.keypadRun = wb_dat_i[KEYPAD_RUN_BIT];
                    end
                end
                default: begin
                    // Unmapped and read-only words ignore writes.
                end
            endcase
            for (int i = 0; i < TERMS; i++) begin
                state_nxt.funcCode[i] = funcWide[i];
            end
        end

        // Run state follows the terminals with no start inhibit after reset.
        state_nxt.running = runWanted; // see RULE7
        state_nxt.reverse = reverseWanted;

        // The set in use is frozen while the motor turns.
        if (!state_r.running) begin
            state_nxt.activeSet = setSelect; // see RULE9 see RULE8
        end

        state_nxt.rdData = '0;
        if (state_nxt.ack && !wb_we_i) begin
            unique case (wb_adr_i)
                FUNC_LO_OFFSET: state_nxt.rdData = funcWide[TERMS_PER_WORD-1:0];
                FUNC_HI_OFFSET: state_nxt.rdData =
                    funcWide[2*TERMS_PER_WORD-1:TERMS_PER_WORD];
                NC_CFG_OFFSET: state_nxt.rdData[TERMS-1:0] = state_r.ncCfg;
                KEYPAD_CTRL_OFFSET: begin
                    state_nxt.rdData[KEYPAD_DIR_BIT] = state_r.keypadRunDirectionSetting;
                    state_nxt.rdData[KEYPAD_RUN_BIT] = state_r.keypadRun;
                end
                RUN_STATUS_OFFSET: state_nxt.rdData = statusWord;
                default: state_nxt.rdData = '0;
            endcase
        end
    end

    // ************************************************************
    // State register
    // ************************************************************
    always_ff @(posedge clock or negedge rstSync_n) begin
        if (!rstSync_n) begin
            state_r.funcCode <= {TERMS{FUNC_NOT_USED}};
            state_r.funcCode[0] <= FUNC_FORWARD_RUN;
            if (TERMS > 1) begin
                state_r.funcCode[TERMS > 1 ? 1 : 0] <= FUNC_REVERSE_RUN;
            end
            state_r.ncCfg <= NC_CFG_RESET[TERMS-1:0];
            state_r.keypadRunDirectionSetting <= KEYPAD_DIR_RESET;
            state_r.keypadRun <= KEYPAD_RUN_RESET;
            state_r.running <= 1'b0;
            state_r.reverse <= 1'b0;
            state_r.activeSet <= 1'b0;
            state_r.ack <= 1'b0;
            state_r.rdData <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign wb_ack_o = state_r.ack;
    assign wb_dat_o = state_r.rdData;
    assign motorRun = state_r.running; // see RULE10
    assign motorReverse = state_r.reverse;
    assign secondSetActive = state_r.activeSet; // see RULE9

endmodule : run_command_input_decode

// [field_switches.sv]
// Purpose: Field switch model driving the input terminals.
// Assumes: A switch energises its terminal high and moves on a clock edge.
// Notes: Slow mode adds contact travel before a new pattern shows.
`timescale 1ns/1ps
module field_switches #(
    parameter int TERMS = 7
) (
    input wire logic clock,
    input wire logic slow,
    input wire logic [TERMS-1:0] wanted,
    output logic [TERMS-1:0] terminalIn
);
    logic [1:0] travel = 2'h0;
    initial terminalIn = '0;
    // Any terminal may carry any pattern; none is treated specially here.
    always @(posedge clock) begin
        travel <= (wanted == terminalIn) ? 2'h0 : travel + 2'h1;
        if (!slow || travel == 2'h3) begin
            terminalIn <= wanted;
        end
    end
endmodule : field_switches

// [run_cmd_chk.sv]
// Purpose: Port checker for the run command input decoder.
// Assumes: Terminal codes keep reset values until a write to a code or polarity word is requested.
// Notes: Terminal rules allow six cycles for reset release, sync and register.
`timescale 1ns/1ps
module run_cmd_chk #(
    parameter int TERMS = 7
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic [TERMS-1:0] terminalIn,
    input wire logic mainPowerOk,
    input wire logic motorRun,
    input wire logic motorReverse,
    input wire logic secondSetActive
);
    logic dirty_r;
    logic defOk;
    assign defOk = !dirty_r && mainPowerOk;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            dirty_r <= 1'b0;
        end else if (wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i < 8'h0c) begin
            dirty_r <= 1'b1;
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    a_ack_after_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
    a_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside ack");
    a_fwd_runs: assert property (
        (defOk && terminalIn[0] && !terminalIn[1])[*6] |=> motorRun && !motorReverse)
        else $error("forward run missing");
    a_rev_runs: assert property (
        (defOk && !terminalIn[0] && terminalIn[1])[*6] |=> motorRun && motorReverse)
        else $error("reverse run missing");
    a_both_stop: assert property (
        (defOk && terminalIn[0] && terminalIn[1])[*6] |=> !motorRun)
        else $error("conflict did not stop");
    a_nopower_stop: assert property ((!mainPowerOk)[*3] |=> !motorRun)
        else $error("motor driven without power");
    a_set_frozen: assert property (motorRun |=> $stable(secondSetActive))
        else $error("set changed while running");
endmodule : run_cmd_chk
bind run_command_input_decode run_cmd_chk #(.TERMS(TERMS)) u_chk (.clock(clock),
    .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .terminalIn(terminalIn), .mainPowerOk(mainPowerOk), .motorRun(motorRun),
    .motorReverse(motorReverse), .secondSetActive(secondSetActive));

// [run_command_input_decode_tb_top.sv]
// Purpose: Self-checking bench for the run command input decoder.
// Assumes: Reset codes put forward on terminal 0 and reverse on terminal 1.
// Notes: Status reads also compare the motor ports, since both must agree.
`timescale 1ns/1ps
module run_command_input_decode_tb_top;
    import run_cmd_pkg::*;
    typedef struct packed {
        logic [31:0] val;
        logic [31:0] mask;
        logic stat;
    } note_s;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] datW = 32'h0;
    logic [31:0] datR;
    logic ack;
    logic [6:0] levels = 7'h01;
    logic [6:0] term;
    logic slow = 1'b0;
    logic powerOk = 1'b1;
    logic run;
    logic rev;
    logic set2;
    int num_errors = 0;
    int checks = 0;
    int seed = 73171;
    logic [31:0] r;
    note_s notes[$];
    note_s n;
    run_command_input_decode DUT (.clock(clock), .rst_n(rst_n), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datW),
        .wb_dat_o(datR), .wb_ack_o(ack), .terminalIn(term), .mainPowerOk(powerOk),
        .motorRun(run), .motorReverse(rev), .secondSetActive(set2));
    field_switches PART (.clock(clock), .slow(slow), .wanted(levels), .terminalIn(term));
    initial begin
        forever #25 clock = ~clock;
    end
    task automatic finish_test;
        if (num_errors == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : finish_test
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
        input logic [3:0] s);
        @(posedge clock);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        datW <= d;
        sel <= s;
        @(posedge clock);
        while (ack !== 1'b1) @(posedge clock);
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : bus
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
        notes.push_back('{v, m, a == RUN_STATUS_OFFSET});
        bus(1'b0, a, 32'h0, 4'hf);
    endtask : rd
    task automatic drive(input logic [6:0] l, input logic p);
        @(posedge clock);
        levels <= l;
        powerOk <= p;
        repeat (10) @(posedge clock);
    endtask : drive
    // Results are judged when the read answer shows, in request order.
    always @(posedge clock) begin
        if (ack === 1'b1 && we === 1'b0 && notes.size() > 0) begin
            n = notes.pop_front();
            checks++;
            if ((((datR ^ n.val) & n.mask) !== 32'h0) ||
                (n.stat && ((({set2, rev, run} ^ n.val[2:0]) & n.mask[2:0]) !== 3'h0))) begin
                num_errors++;
                $display("[FAIL] %0t read %h want %h mask %h", $time, datR, n.val, n.mask);
            end
        end
    end
    initial begin
        repeat (5000) @(posedge clock);
        num_errors++;
        $display("[FAIL] %0t timeout", $time);
        finish_test();
    end
    initial begin
        repeat (6) @(posedge clock);
        rst_n <= 1'b1;
        repeat (8) @(posedge clock);
        rd(RUN_STATUS_OFFSET, 32'h7f, 32'h31);
        bus(1'b1, KEYPAD_CTRL_OFFSET, 32'h1, 4'h1);
        rd(KEYPAD_CTRL_OFFSET, 32'h3, 32'h1);
        for (int k = 0; k < 16; k++) begin
            r = $random(seed);
            drive({r[6:2], k[1:0]}, 1'b1);
            case (k[1:0])
                2'b01: rd(RUN_STATUS_OFFSET, 32'h7f, 32'h31);
                2'b10: rd(RUN_STATUS_OFFSET, 32'h7f, 32'h53);
                2'b11: rd(RUN_STATUS_OFFSET, 32'h7d, 32'h70);
                default: rd(RUN_STATUS_OFFSET, 32'h7d, 32'h10);
            endcase
        end
        slow <= 1'b1;
        drive(7'h01, 1'b0);
        rd(RUN_STATUS_OFFSET, 32'h11, 32'h0);
        bus(1'b1, KEYPAD_CTRL_OFFSET, 32'h0, 4'h1);
        rd(KEYPAD_CTRL_OFFSET, 32'h3, 32'h0);
        slow <= 1'b0;
        bus(1'b1, RUN_STATUS_OFFSET, 32'hffffffff, 4'hf);
        rd(8'h20, 32'hffffffff, 32'h0);
        bus(1'b1, NC_CFG_OFFSET, 32'h1, 4'h1);
        drive(7'h00, 1'b1);
        rd(NC_CFG_OFFSET, 32'h7f, 32'h1);
        rd(RUN_STATUS_OFFSET, 32'h7f, 32'h31);
        drive(7'h01, 1'b1);
        rd(RUN_STATUS_OFFSET, 32'h7d, 32'h10);
        bus(1'b1, NC_CFG_OFFSET, 32'h0, 4'h1);
        bus(1'b1, FUNC_LO_OFFSET, 32'h00080000, 4'h4);
        rd(FUNC_LO_OFFSET, 32'hffffffff, 32'hff080100);
        drive(7'h04, 1'b1);
        rd(RUN_STATUS_OFFSET, 32'h7d, 32'h1c);
        drive(7'h05, 1'b1);
        rd(RUN_STATUS_OFFSET, 32'h7f, 32'h3d);
        drive(7'h01, 1'b1);
        rd(RUN_STATUS_OFFSET, 32'h7f, 32'h35);
        drive(7'h00, 1'b1);
        rd(RUN_STATUS_OFFSET, 32'h7d, 32'h10);
        bus(1'b1, FUNC_HI_OFFSET, 32'h00010000, 4'h4);
        drive(7'h40, 1'b1);
        rd(RUN_STATUS_OFFSET, 32'h7f, 32'h53);
        bus(1'b1, KEYPAD_CTRL_OFFSET, 32'h3, 4'h1);
        drive(7'h00, 1'b1);
        rd(RUN_STATUS_OFFSET, 32'h7f, 32'h13);
        drive(7'h01, 1'b1);
        rd(RUN_STATUS_OFFSET, 32'h7f, 32'h31);
        repeat (4) @(posedge clock);
        finish_test();
    end
endmodule : run_command_input_decode_tb_top
